// [core/cpu_status_flag_register.sv]
// processor status flag register with alu and apb access
`timescale 1ns/1ps
module cpu_status_flag_register
  import status_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        wdtTimeout,
  input  wire logic        sleepEntry,
  input  wire logic        wdtClear,
  input  wire logic [7:0]  directAddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  status,
  output logic      [7:0]  bankAddr,
  output logic      [7:0]  aluResult
);
  import status_pkg::*;

  logic       rstSync1_q;
  logic       rstSync1_d;
  logic       rstSync_q;
  logic       rstSync_d;
  logic       rstN;
  // release passes two flops so no state leaves reset near a clock edge
  always_comb begin
    rstSync1_d = 1'b1;
    rstSync_d  = rstSync1_q;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_q <= 1'b0;
      rstSync_q  <= 1'b0;
    end else begin
      rstSync1_q <= rstSync1_d;
      rstSync_q  <= rstSync_d;
    end
  end
  assign rstN = rstSync_q;

  // pin events cross in from outside the core clock
  logic timeoutS;
  logic sleepS;
  logic clearS;
  logic timeoutPrev_q;
  logic sleepPrev_q;
  logic clearPrev_q;
  logic timeoutPrev_d;
  logic sleepPrev_d;
  logic clearPrev_d;
  sync3 uSyncTo (
    .clk  (clk),
    .rstN (rstN),
    .ce   (ce),
    .din  (wdtTimeout),
    .dout (timeoutS)
  );
  sync3 uSyncSl (
    .clk  (clk),
    .rstN (rstN),
    .ce   (ce),
    .din  (sleepEntry),
    .dout (sleepS)
  );
  sync3 uSyncCl (
    .clk  (clk),
    .rstN (rstN),
    .ce   (ce),
    .din  (wdtClear),
    .dout (clearS)
  );

  // operation request register: op[3:0], dest-is-status[4], bit select[7:5], operand a [15:8], operand b [23:16]
  logic [23:0] opReq_q;
  logic [23:0] opReq_d;
  logic        fire_q;
  logic        fire_d;
  logic [7:0]  status_q;
  logic [7:0]  status_d;
  logic [7:0]  result_q;
  logic [7:0]  result_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [7:0]  bank_q;
  logic [7:0]  bank_d;

  logic [7:0]  aluOut;
  logic        zeroOut;
  logic        nibbleOut;
  logic        carryOut;
  logic        setsZero;
  logic        setsArith;
  logic        destStatus;
  logic [7:0]  operandB;

  assign destStatus = opReq_q[4];
  // a status-destined op reads the register itself as its file operand
  assign operandB   = destStatus ? status_q : opReq_q[23:16];

  status_alu uAlu (
    .op        (opReq_q[3:0]),
    .opA       (opReq_q[15:8]),
    .opB       (operandB),
    .bitSel    (opReq_q[7:5]),
    .carryIn   (status_q[CARRY_BIT]),
    .result    (aluOut),
    .zeroOut   (zeroOut),
    .nibbleOut (nibbleOut),
    .carryOut  (carryOut),
    .setsZero  (setsZero),
    .setsArith (setsArith)
  );

  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic toRise;
  logic slRise;
  logic clRise;
  assign apbAccess = psel && penable && !pready_q;
  assign apbWrite  = apbAccess && pwrite;
  assign apbRead   = apbAccess && !pwrite;
  assign toRise    = timeoutS && !timeoutPrev_q;
  assign slRise    = sleepS && !sleepPrev_q;
  assign clRise    = clearS && !clearPrev_q;

  // edge memory follows the filtered level
  always_comb begin
    timeoutPrev_d = timeoutS;
    sleepPrev_d   = sleepS;
    clearPrev_d   = clearS;
  end

  // apb slave, one wait state: answer comes the cycle after access starts
  always_comb begin
    opReq_d   = opReq_q;
    fire_d    = 1'b0;
    pready_d  = apbAccess;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (apbAccess) begin
      // status is read-only here; a write is dropped without error
      case (paddr)
        STATUS_OFF: prdata_d = {24'h000000, status_q};
        OPREQ_OFF: begin
          prdata_d = {8'h00, opReq_q};
          if (apbWrite) begin
            opReq_d = pwdata[23:0];
            fire_d  = 1'b1;
          end
        end
        RESULT_OFF: begin
          prdata_d  = {24'h000000, result_q};
          pslverr_d = apbWrite;
        end
        EVENT_OFF: begin
          prdata_d  = {29'h0000000, clearS, sleepS, timeoutS};
          pslverr_d = apbWrite;
        end
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // status update from the executed operation
  always_comb begin
    status_d = status_q;
    result_d = result_q;
    if (fire_q) begin
      result_d = aluOut;
      if (destStatus) begin
        // the upper bank bits always take the written value
        status_d[INDIR_BIT] = aluOut[INDIR_BIT];
        status_d[UPPER_BIT] = aluOut[UPPER_BIT];
        status_d[BANK_BIT]  = aluOut[BANK_BIT];
        // zero, nibble and carry bits are written only if the op leaves them alone
        if (!setsZero) begin
          status_d[ZERO_BIT] = aluOut[ZERO_BIT];
        end
        // clear keeps nibble and carry as they were
        if (!setsArith && opReq_q[3:0] != OP_CLR) begin
          status_d[NIBBLE_BIT] = aluOut[NIBBLE_BIT];
          status_d[CARRY_BIT]  = aluOut[CARRY_BIT];
        end
        // reset-cause bits never take the written value
        status_d[WDT_BIT]   = status_q[WDT_BIT];
        status_d[SLEEP_BIT] = status_q[SLEEP_BIT];
      end
      // flag results override any written value
      if (setsZero) begin
        status_d[ZERO_BIT] = zeroOut;
      end
      if (setsArith) begin
        status_d[NIBBLE_BIT] = nibbleOut;
        status_d[CARRY_BIT]  = carryOut;
      end
      if (opReq_q[3:0] == OP_RRF || opReq_q[3:0] == OP_RLF) begin
        status_d[CARRY_BIT] = carryOut;
      end
    end
    // hardware events; later lines take priority
    if (clRise) begin
      status_d[WDT_BIT]   = 1'b1;
      status_d[SLEEP_BIT] = 1'b1;
    end
    if (slRise) begin
      status_d[WDT_BIT]   = 1'b1;
      status_d[SLEEP_BIT] = 1'b0;
    end
    if (toRise) begin
      status_d[WDT_BIT] = 1'b0;
    end
  end

  // bank-qualified address; reserved bits ignored as the device does not use them
  always_comb begin
    bank_d = status_q[BANK_BIT] ? (directAddr | BANK_SPLIT) : (directAddr & ~BANK_SPLIT);
  end

  // bus answer and operation request registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      opReq_q   <= 24'h000000;
      fire_q    <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      opReq_q   <= opReq_d;
      fire_q    <= fire_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      status_q <= STATUS_RST;
      result_q <= 8'h00;
    end else if (ce) begin
      status_q <= status_d;
      result_q <= result_d;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      bank_q <= 8'h00;
    end else if (ce) begin
      bank_q <= bank_d;
    end
  end

  // cleared edge memory matches the idle-low pins, so reset makes no false edge
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      timeoutPrev_q <= 1'b0;
      sleepPrev_q   <= 1'b0;
      clearPrev_q   <= 1'b0;
    end else if (ce) begin
      timeoutPrev_q <= timeoutPrev_d;
      sleepPrev_q   <= sleepPrev_d;
      clearPrev_q   <= clearPrev_d;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign status    = status_q;
  assign bankAddr  = bank_q;
  assign aluResult = result_q;
endmodule // cpu_status_flag_register

// [core/status_alu.sv]
// alu computing result and arithmetic flags
`timescale 1ns/1ps
module status_alu
  import status_pkg::*;
(
  input  wire logic [3:0] op,
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  input  wire logic [2:0] bitSel,
  input  wire logic       carryIn,
  output logic      [7:0] result,
  output logic            zeroOut,
  output logic            nibbleOut,
  output logic            carryOut,
  output logic            setsZero,
  output logic            setsArith
);
  logic [8:0] wide;
  logic [4:0] low;
  always_comb begin
    wide      = 9'h000;
    low       = 5'h00;
    result    = opB;
    nibbleOut = 1'b0;
    carryOut  = carryIn;
    setsZero  = 1'b0;
    setsArith = 1'b0;
    case (op)
      OP_MOVE: result = opA;
      OP_CLR: begin
        result   = 8'h00;
        setsZero = 1'b1;
      end
      OP_ADD: begin
        wide      = {1'b0, opA} + {1'b0, opB};
        low       = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
        result    = wide[7:0];
        nibbleOut = low[4];
        carryOut  = wide[8];
        setsZero  = 1'b1;
        setsArith = 1'b1;
      end
      OP_SUB: begin
        // b - a as b + ~a + 1, so carry reads as not-borrow
        wide      = {1'b0, opB} + {1'b0, ~opA} + 9'h001;
        low       = {1'b0, opB[3:0]} + {1'b0, ~opA[3:0]} + 5'h01;
        result    = wide[7:0];
        nibbleOut = low[4];
        carryOut  = wide[8];
        setsZero  = 1'b1;
        setsArith = 1'b1;
      end
      OP_AND: begin
        result   = opA & opB;
        setsZero = 1'b1;
      end
      OP_OR: begin
        result   = opA | opB;
        setsZero = 1'b1;
      end
      OP_XOR: begin
        result   = opA ^ opB;
        setsZero = 1'b1;
      end
      OP_RRF: begin
        result   = {carryIn, opB[7:1]};
        carryOut = opB[0];
      end
      OP_RLF: begin
        result   = {opB[6:0], carryIn};
        carryOut = opB[7];
      end
      OP_BCF: result = opB & ~(8'h01 << bitSel);
      OP_BSF: result = opB | (8'h01 << bitSel);
      OP_SWAP: result = {opB[3:0], opB[7:4]};
      default: result = opB;
    endcase
    zeroOut = (result == 8'h00);
  end
endmodule // status_alu

// [core/sync3.sv]
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module sync3 (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] pipe_q;
  logic [2:0] pipe_d;
  logic       out_q;
  logic       out_d;
  always_comb begin
    pipe_d = {pipe_q[1:0], din};
    out_d  = (pipe_q[2] == pipe_q[1]) ? pipe_q[2] : out_q;
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pipe_q <= 3'h0;
      out_q  <= 1'b0;
    end else if (ce) begin
      pipe_q <= pipe_d;
      out_q  <= out_d;
    end
  end
  assign dout = out_q;
endmodule // sync3

// [shared/status_pkg.sv]
// constants for the processor status flag register
package status_pkg;
  localparam int          DATA_W      = 8;
  // apb map
  localparam logic [7:0]  STATUS_OFF  = 8'h00;
  localparam logic [7:0]  OPREQ_OFF   = 8'h04;
  localparam logic [7:0]  RESULT_OFF  = 8'h08;
  localparam logic [7:0]  EVENT_OFF   = 8'h0c;
  // field positions in the status register
  localparam int          CARRY_BIT   = 0;
  localparam int          NIBBLE_BIT  = 1;
  localparam int          ZERO_BIT    = 2;
  localparam int          SLEEP_BIT   = 3;
  localparam int          WDT_BIT     = 4;
  localparam int          BANK_BIT    = 5;
  localparam int          UPPER_BIT   = 6;
  localparam int          INDIR_BIT   = 7;
  // power-on value; arithmetic flags unknown, taken as zero
  localparam logic [7:0]  STATUS_RST  = 8'h18;
  localparam logic [7:0]  BANK_SPLIT  = 8'h80;
  // operation codes
  typedef enum logic [3:0] {
    OP_MOVE  = 4'h0, // move_acc_to_file_instr, no flags
    OP_CLR   = 4'h1, // clear_file_instr
    OP_ADD   = 4'h2, // add_acc_file_instr / add_literal_instr
    OP_SUB   = 4'h3, // sub_acc_file_instr / sub_from_literal_instr
    OP_AND   = 4'h4,
    OP_OR    = 4'h5,
    OP_XOR   = 4'h6,
    OP_RRF   = 4'h7,
    OP_RLF   = 4'h8,
    OP_BCF   = 4'h9,
    OP_BSF   = 4'ha,
    OP_SWAP  = 4'hb
  } op_e;
endpackage

// [sim/cpu_status_flag_register_assertions.sv]
// port-level checks on the status flag register
`timescale 1ns/1ps
module cpu_status_flag_register_assertions
  import status_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        wdtTimeout,
  input wire logic        sleepEntry,
  input wire logic        wdtClear,
  input wire logic [7:0]  directAddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  status,
  input wire logic [7:0]  bankAddr,
  input wire logic [7:0]  aluResult
);
  logic [23:0] req_q;
  logic [23:0] req_d;
  wire       fire  = ce && psel && penable && pready && pwrite && paddr == OPREQ_OFF;
  wire       newOp = fire && !pwdata[4];
  wire [8:0] sum   = {1'b0, req_q[15:8]} + {1'b0, req_q[23:16]};
  wire [4:0] nib   = {1'b0, req_q[11:8]} + {1'b0, req_q[19:16]};
  wire [8:0] dif   = {1'b0, req_q[23:16]} + {1'b0, ~req_q[15:8]} + 9'h001;
  always_comb req_d = fire ? pwdata[23:0] : req_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) req_q <= '0;
    else req_q <= req_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_add;
    newOp && pwdata[3:0] == OP_ADD |-> ##[1:3]
      (aluResult == sum[7:0] && status[CARRY_BIT] == sum[8] && status[NIBBLE_BIT] == nib[4]);
  endproperty
  a_add: assert property (p_add) else $error("add flags wrong");
  property p_sub;
    newOp && pwdata[3:0] == OP_SUB |-> ##[1:3] (aluResult == dif[7:0] && status[CARRY_BIT] == dif[8]);
  endproperty
  a_sub: assert property (p_sub) else $error("sub borrow wrong");
  property p_zero;
    newOp && pwdata[3:0] inside {OP_AND, OP_OR, OP_XOR} |-> ##[1:3] status[ZERO_BIT] == (aluResult == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_bank;
    ce |=> bankAddr == {$past(status[BANK_BIT]), $past(directAddr[6:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");
  property p_tmo;
    $rose(wdtTimeout) |-> ##[1:8] !status[WDT_BIT];
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not flagged");
  property p_sleep;
    $rose(sleepEntry) |-> ##[1:8] (status[WDT_BIT] && !status[SLEEP_BIT]);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not flagged");
  property p_wclr;
    $rose(wdtClear) |-> ##[1:8] (status[WDT_BIT] && status[SLEEP_BIT]);
  endproperty
  a_wclr: assert property (p_wclr) else $error("watchdog clear not flagged");
  property p_cause;
    (!wdtTimeout && !sleepEntry && !wdtClear) [*8] |=> $stable(status[4:3]);
  endproperty
  a_cause: assert property (p_cause) else $error("reset cause moved");
  property p_err;
    ce && psel && penable && !pready && paddr > EVENT_OFF |=> pready && pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no error on unmapped");
  c_op: cover property (newOp);
  c_sleep: cover property ($rose(sleepEntry));
  c_err: cover property (pready && pslverr);
endmodule // cpu_status_flag_register_assertions

bind cpu_status_flag_register cpu_status_flag_register_assertions cpu_status_flag_register_assertions_inst (.*);

// [sim/cpu_status_flag_register_tb.sv]
// self-checking bench for the status flag register
`timescale 1ns/1ps
module cpu_status_flag_register_tb;
  import status_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        wdtTimeout = 1'b0;
  logic        sleepEntry = 1'b0;
  logic        wdtClear = 1'b0;
  logic [7:0]  directAddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  status;
  logic [7:0]  bankAddr;
  logic [7:0]  aluResult;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          num_checks = 0;

  always #20 clk = ~clk;

  cpu_status_flag_register cpu_status_flag_register_inst (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .wdtTimeout (wdtTimeout),
    .sleepEntry (sleepEntry),
    .wdtClear   (wdtClear),
    .directAddr (directAddr),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .status     (status),
    .bankAddr   (bankAddr),
    .aluResult  (aluResult)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // request held until pready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic runOp(input logic [3:0] o, input logic d, input logic [2:0] s,
                       input logic [7:0] a, input logic [7:0] b, input logic [7:0] r, input logic [7:0] e);
    xfer(OPREQ_OFF, 1'b1, {8'h00, b, a, s, d, o});
    repeat (3) @(posedge clk);
    xfer(STATUS_OFF, 1'b0, 32'h0);
    chk(rd, {24'h0, e}, "status");
    chk(32'(aluResult), 32'(r), "result");
  endtask

  task automatic evt(input logic [2:0] p, input logic [7:0] e);
    {wdtTimeout, sleepEntry, wdtClear} <= p;
    repeat (10) @(posedge clk);
    {wdtTimeout, sleepEntry, wdtClear} <= 3'b000;
    repeat (10) @(posedge clk);
    chk(32'(status), 32'(e), "event");
  endtask

  task automatic t_bus();
    chk(32'(status), 32'h18, "reset");
    xfer(8'h10, 1'b0, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
    xfer(RESULT_OFF, 1'b1, 32'h0);
    chk(32'(err), 32'h1, "ro write");
    xfer(STATUS_OFF, 1'b1, 32'hff);
    xfer(STATUS_OFF, 1'b0, 32'h0);
    chk(rd, 32'h18, "status write");
  endtask

  // status as destination: protected bits and flag override
  task automatic t_dest();
    directAddr <= 8'h12;
    runOp(OP_MOVE, 1'b1, 3'h0, 8'h00, 8'h00, 8'h00, 8'h18);
    runOp(OP_MOVE, 1'b1, 3'h0, 8'he7, 8'h00, 8'he7, 8'hff);
    runOp(OP_CLR, 1'b1, 3'h0, 8'h00, 8'h00, 8'h00, 8'h1f);
    runOp(OP_ADD, 1'b1, 3'h0, 8'h00, 8'h55, 8'h1f, 8'h18);
    runOp(OP_BSF, 1'b1, 3'h5, 8'h00, 8'h00, 8'h38, 8'h38);
    chk(32'(bankAddr), 32'h92, "bank one");
    runOp(OP_BCF, 1'b1, 3'h5, 8'h00, 8'h00, 8'h18, 8'h18);
    chk(32'(bankAddr), 32'h12, "bank zero");
  endtask

  task automatic t_flags();
    runOp(OP_ADD, 1'b0, 3'h0, 8'h0f, 8'h01, 8'h10, 8'h1a);
    runOp(OP_ADD, 1'b0, 3'h0, 8'hff, 8'h01, 8'h00, 8'h1f);
    runOp(OP_SUB, 1'b0, 3'h0, 8'h05, 8'h05, 8'h00, 8'h1f);
    runOp(OP_SUB, 1'b0, 3'h0, 8'h01, 8'h00, 8'hff, 8'h18);
    runOp(OP_RLF, 1'b0, 3'h0, 8'h00, 8'h80, 8'h00, 8'h19);
    runOp(OP_RRF, 1'b0, 3'h0, 8'h00, 8'h02, 8'h81, 8'h18);
    runOp(OP_AND, 1'b0, 3'h0, 8'hf0, 8'h0f, 8'h00, 8'h1c);
    runOp(OP_OR, 1'b0, 3'h0, 8'hf0, 8'h0f, 8'hff, 8'h18);
    runOp(OP_XOR, 1'b0, 3'h0, 8'h55, 8'h55, 8'h00, 8'h1c);
    runOp(OP_SWAP, 1'b0, 3'h0, 8'h00, 8'h3c, 8'hc3, 8'h1c);
  endtask

  task automatic t_events();
    evt(3'b100, 8'h0c);
    evt(3'b010, 8'h14);
    evt(3'b001, 8'h1c);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_bus();
    t_dest();
    t_flags();
    t_events();
    tally_and_finish();
  end
endmodule // cpu_status_flag_register_tb
